// *** hdl/clsd_core.sv ***
// decode and execute of compact load/store, multiple transfer and add forms
// assumes one clock, a pipeline that holds instr until ready, and a memory
// port that answers each request with a one-cycle ack
`timescale 1ns/1ps
`default_nettype none

module clsd_core (
  // clock and reset
  input  wire  logic        clk,
  input  wire  logic        reset_n,
  // instruction issue
  input  wire  logic        instr_valid,
  input  wire  logic [15:0] instr,
  input  wire  logic [31:0] instr_pc,
  output logic              instr_ready,
  output logic              instr_done,
  output logic              instr_undef,
  output logic              pc_load_valid,
  output logic [31:0]       pc_load_value,
  // memory data port
  output logic              mem_req,
  output logic              mem_we,
  output logic [31:0]       mem_addr,
  output logic [31:0]       mem_wdata,
  output logic [1:0]        mem_size,
  input  wire  logic        mem_ack,
  input  wire  logic [31:0] mem_rdata,
  // register port
  input  wire  logic [3:0]  reg_addr,
  input  wire  logic [31:0] reg_wdata,
  input  wire  logic        reg_wr,
  input  wire  logic        reg_rd,
  output logic [31:0]       reg_rdata,
  // condition flags
  output logic              flag_n,
  output logic              flag_z,
  output logic              flag_c,
  output logic              flag_v
);

  // ----------------------------------------------------------------
  // helper functions
  // ----------------------------------------------------------------

  // number of registers named in a nine-bit list
  function automatic logic [3:0] list_count(input logic [8:0] l);
    logic [3:0] n;
    n = 4'h0;
    for (int i = 0; i < 9; i++) begin
      n = n + {3'h0, l[i]};
    end
    return n;
  endfunction

  // index of the lowest set bit of a list
  function automatic logic [3:0] list_lowest(input logic [8:0] l);
    logic [3:0] k;
    k = 4'h0;
    for (int i = 8; i >= 0; i--) begin
      if (l[i]) begin
        k = 4'(i);
      end
    end
    return k;
  endfunction

  // widen loaded data by size and signedness
  function automatic logic [31:0] load_extend(input logic [31:0] d, input logic [1:0] sz, input logic sgn);
    logic [31:0] r;
    r = d;
    if (sz == clsd_pkg::SZ_BYTE) begin
      r = {{24{sgn & d[7]}}, d[7:0]};
    end else if (sz == clsd_pkg::SZ_HALF) begin
      r = {{16{sgn & d[15]}}, d[15:0]};
    end
    return r;
  endfunction

  // size of a register-offset operation
  function automatic logic [1:0] rop_size(input logic [2:0] op);
    logic [1:0] s;
    s = clsd_pkg::SZ_WORD;
    if (op == clsd_pkg::ROP_HALF_STORE || op == clsd_pkg::ROP_UNSIGNED_HALF_LD ||
        op == clsd_pkg::ROP_SIGNED_HALF_LOAD) begin
      s = clsd_pkg::SZ_HALF;
    end else if (op == clsd_pkg::ROP_BYTE_STORE || op == clsd_pkg::ROP_UNSIGNED_BYTE_LD ||
                 op == clsd_pkg::ROP_SIGNED_BYTE_LOAD) begin
      s = clsd_pkg::SZ_BYTE;
    end
    return s;
  endfunction

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  clsd_pkg::clsd_state_t state_reg;
  clsd_pkg::clsd_state_t state_next;
  logic [31:0]           rf_reg [clsd_pkg::NUM_REGS];
  logic                  n_reg, z_reg, c_reg, v_reg;
  logic [3:0]            s_idx_reg;
  logic [1:0]            s_size_reg;
  logic                  s_signed_reg;
  logic                  s_load_reg;
  logic [8:0]            m_list_reg;
  logic [31:0]           m_addr_reg;
  logic [31:0]           m_final_reg;
  logic [3:0]            m_base_reg;
  logic                  m_load_reg;
  logic [3:0]            m_cur_reg;
  logic                  ready_reg, done_reg, undef_reg, pcv_reg;
  logic [31:0]           pcval_reg;
  logic                  req_reg, we_reg;
  logic [31:0]           addr_reg, wdata_reg, rdata_reg;
  logic [1:0]            size_reg;

  // ----------------------------------------------------------------
  // field extraction and opcode match
  // ----------------------------------------------------------------
  wire        accept    = instr_valid & ready_reg & (state_reg == clsd_pkg::ST_IDLE);
  wire [3:0]  f_rd      = {1'b0, instr[clsd_pkg::F_RD +: 3]};
  wire [3:0]  f_rn      = {1'b0, instr[clsd_pkg::F_RN +: 3]};
  wire [3:0]  f_rm      = {1'b0, instr[clsd_pkg::F_RM +: 3]};
  wire [3:0]  f_hrd     = {1'b0, instr[clsd_pkg::F_HRD +: 3]};
  wire [4:0]  f_imm5    = instr[clsd_pkg::F_IMM5 +: 5];
  wire [7:0]  f_imm8    = instr[clsd_pkg::F_IMM8 +: 8];
  wire [2:0]  f_imm3    = instr[clsd_pkg::F_RM +: 3];
  wire [2:0]  f_rop     = instr[clsd_pkg::F_ROP +: 3];
  wire        f_l       = instr[clsd_pkg::F_LBIT];
  wire        f_b       = instr[clsd_pkg::F_BBIT];

  wire        is_adc    = instr[15:6] == clsd_pkg::OP_ADC;
  wire        is_add3   = instr[15:9] == clsd_pkg::OP_ADD3;
  wire        is_add8   = instr[15:11] == clsd_pkg::OP_ADD8;
  wire        is_imm_wb = instr[15:13] == clsd_pkg::OP_IMM_WB;
  wire        is_imm_h  = instr[15:12] == clsd_pkg::OP_IMM_H;
  wire        is_reg    = instr[15:12] == clsd_pkg::OP_REG;
  wire        is_lit    = instr[15:11] == clsd_pkg::OP_LIT;
  wire        is_sp     = instr[15:12] == clsd_pkg::OP_SP;
  wire        is_pp     = instr[15:12] == clsd_pkg::OP_PP && instr[clsd_pkg::F_PP];
  wire        is_blk    = instr[15:12] == clsd_pkg::OP_BLK;
  wire        is_alu    = is_adc | is_add3 | is_add8;
  wire        is_single = is_imm_wb | is_imm_h | is_reg | is_lit | is_sp;
  wire        is_multi  = is_pp | is_blk;

  // ----------------------------------------------------------------
  // single transfer address, size and data register
  // ----------------------------------------------------------------
  wire [31:0] imm5_w    = {27'h0, f_imm5} << clsd_pkg::SCALE_WORD;
  wire [31:0] imm5_h    = {27'h0, f_imm5} << clsd_pkg::SCALE_HALF;
  wire [31:0] imm8_w    = {24'h0, f_imm8} << clsd_pkg::SCALE_WORD;
  wire [31:0] imm5_off  = is_imm_h ? imm5_h : (f_b ? {27'h0, f_imm5} : imm5_w);
  wire [31:0] s_addr    = is_reg   ? rf_reg[f_rn] + rf_reg[f_rm] :
                          is_lit   ? (instr_pc & clsd_pkg::PC_ALIGN) + imm8_w :
                          is_sp    ? rf_reg[clsd_pkg::IDX_SP] + imm8_w :
                          rf_reg[f_rn] + imm5_off;
  wire [1:0]  s_size    = is_reg   ? rop_size(f_rop) :
                          is_imm_h ? clsd_pkg::SZ_HALF :
                          (is_imm_wb & f_b) ? clsd_pkg::SZ_BYTE : clsd_pkg::SZ_WORD;
  wire        s_load    = is_reg ? (f_rop[2] | (f_rop == clsd_pkg::ROP_SIGNED_BYTE_LOAD)) :
                          is_lit ? 1'b1 : f_l;
  wire        s_signed  = is_reg & (f_rop == clsd_pkg::ROP_SIGNED_BYTE_LOAD ||
                                    f_rop == clsd_pkg::ROP_SIGNED_HALF_LOAD);
  wire [3:0]  s_idx     = (is_lit | is_sp) ? f_hrd : f_rd;

  // ----------------------------------------------------------------
  // multiple transfer setup
  // ----------------------------------------------------------------
  wire [8:0]  m_list    = {is_pp & instr[clsd_pkg::F_RBIT], f_imm8};
  wire [31:0] m_bytes   = {28'h0, list_count(m_list)} << clsd_pkg::SCALE_WORD;
  wire [3:0]  m_base    = is_pp ? clsd_pkg::IDX_SP : f_hrd;
  wire [31:0] m_base_v  = rf_reg[m_base];
  wire        m_push    = is_pp & ~f_l;
  wire [31:0] m_start   = m_push ? m_base_v - m_bytes : m_base_v;
  wire [31:0] m_final   = m_push ? m_base_v - m_bytes : m_base_v + m_bytes;
  wire [3:0]  m_pick    = list_lowest(m_list_reg);
  wire [31:0] m_wdata   = (m_pick == clsd_pkg::IDX_EXTRA) ? rf_reg[clsd_pkg::IDX_LR] : rf_reg[m_pick];

  // ----------------------------------------------------------------
  // adder for the arithmetic forms
  // ----------------------------------------------------------------
  wire [31:0] alu_a     = is_add3 ? rf_reg[f_rn] : (is_add8 ? rf_reg[f_hrd] : rf_reg[f_rd]);
  // adc takes its second register from 5:3, not the offset slot
  wire [31:0] alu_b     = is_add3 ? {29'h0, f_imm3} : (is_add8 ? {24'h0, f_imm8} : rf_reg[f_rn]);
  wire        alu_cin   = is_adc & c_reg;
  wire [32:0] alu_sum   = {1'b0, alu_a} + {1'b0, alu_b} + {32'h0, alu_cin};
  wire [3:0]  alu_dst   = is_add8 ? f_hrd : f_rd;
  wire        alu_n     = alu_sum[31];
  wire        alu_z     = alu_sum[31:0] == 32'h0000_0000;
  wire        alu_c     = alu_sum[32];
  wire        alu_v     = (alu_a[31] == alu_b[31]) && (alu_sum[31] != alu_a[31]);

  // ----------------------------------------------------------------
  // core register write port, one write per cycle
  // ----------------------------------------------------------------
  wire        ack_s     = (state_reg == clsd_pkg::ST_SWAIT) & mem_ack;
  wire        ack_m     = (state_reg == clsd_pkg::ST_MWAIT) & mem_ack;
  wire        cw_alu    = accept & is_alu;
  wire        cw_sload  = ack_s & s_load_reg;
  wire        cw_mload  = ack_m & m_load_reg & (m_cur_reg != clsd_pkg::IDX_EXTRA);
  wire        cw_wb     = state_reg == clsd_pkg::ST_MWB;
  wire        cw_en     = cw_alu | cw_sload | cw_mload | cw_wb;
  wire [3:0]  cw_idx    = cw_alu ? alu_dst : cw_sload ? s_idx_reg : cw_mload ? m_cur_reg : m_base_reg;
  wire [31:0] cw_data   = cw_alu   ? alu_sum[31:0] :
                          cw_sload ? load_extend(mem_rdata, s_size_reg, s_signed_reg) :
                          cw_mload ? mem_rdata : m_final_reg;
  wire        pw_en     = reg_wr & (reg_addr < 4'(clsd_pkg::NUM_REGS)) & ~cw_en;
  wire        fw_en     = reg_wr & (reg_addr == clsd_pkg::ADDR_FLAGS);

  // read-back mux of the register port
  wire [31:0] rd_mux    = (reg_addr < 4'(clsd_pkg::NUM_REGS)) ? rf_reg[reg_addr] :
                          (reg_addr == clsd_pkg::ADDR_FLAGS) ? {28'h0, n_reg, z_reg, c_reg, v_reg} :
                          (reg_addr == clsd_pkg::ADDR_STATUS) ? {31'h0, ~ready_reg} : 32'h0000_0000;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      clsd_pkg::ST_IDLE: begin
        if (accept & is_single) begin
          state_next = clsd_pkg::ST_SWAIT;
        end else if (accept & is_multi) begin
          state_next = clsd_pkg::ST_MISSUE;
        end
      end
      clsd_pkg::ST_SWAIT: begin
        if (mem_ack) begin
          state_next = clsd_pkg::ST_IDLE;
        end
      end
      clsd_pkg::ST_MISSUE: begin
        state_next = (m_list_reg == 9'h000) ? clsd_pkg::ST_MWB : clsd_pkg::ST_MWAIT;
      end
      clsd_pkg::ST_MWAIT: begin
        if (mem_ack) begin
          state_next = clsd_pkg::ST_MISSUE;
        end
      end
      default: begin
        state_next = clsd_pkg::ST_IDLE;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // register file and flags
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      for (int i = 0; i < clsd_pkg::NUM_REGS; i++) begin
        rf_reg[i] <= 32'h0000_0000;
      end
    end else if (cw_en) begin
      rf_reg[cw_idx] <= cw_data;
    end else if (pw_en) begin
      rf_reg[reg_addr] <= reg_wdata;
    end
  end

  // flags follow the adder, else a port write
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      {n_reg, z_reg, c_reg, v_reg} <= 4'h0;
    end else if (cw_alu) begin
      {n_reg, z_reg, c_reg, v_reg} <= {alu_n, alu_z, alu_c, alu_v};
    end else if (fw_en) begin
      {n_reg, z_reg, c_reg, v_reg} <= reg_wdata[3:0];
    end
  end

  // ----------------------------------------------------------------
  // sequencer and memory port
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_reg    <= clsd_pkg::ST_IDLE;
      req_reg      <= 1'b0;
      we_reg       <= 1'b0;
      addr_reg     <= 32'h0000_0000;
      wdata_reg    <= 32'h0000_0000;
      size_reg     <= clsd_pkg::SZ_WORD;
      s_idx_reg    <= 4'h0;
      s_size_reg   <= clsd_pkg::SZ_WORD;
      s_signed_reg <= 1'b0;
      s_load_reg   <= 1'b0;
      m_list_reg   <= 9'h000;
      m_addr_reg   <= 32'h0000_0000;
      m_final_reg  <= 32'h0000_0000;
      m_base_reg   <= 4'h0;
      m_load_reg   <= 1'b0;
      m_cur_reg    <= 4'h0;
    end else begin
      state_reg <= state_next;
      if (accept & is_single) begin
        req_reg      <= 1'b1;
        we_reg       <= ~s_load;
        addr_reg     <= s_addr;
        wdata_reg    <= rf_reg[s_idx];
        size_reg     <= s_size;
        s_idx_reg    <= s_idx;
        s_size_reg   <= s_size;
        s_signed_reg <= s_signed;
        s_load_reg   <= s_load;
      end else if (accept & is_multi) begin
        m_list_reg   <= m_list;
        m_addr_reg   <= m_start;
        m_final_reg  <= m_final;
        m_base_reg   <= m_base;
        m_load_reg   <= f_l;
      end else if (state_reg == clsd_pkg::ST_MISSUE && m_list_reg != 9'h000) begin
        req_reg      <= 1'b1;
        we_reg       <= ~m_load_reg;
        addr_reg     <= m_addr_reg;
        wdata_reg    <= m_wdata;
        size_reg     <= clsd_pkg::SZ_WORD;
        m_cur_reg    <= m_pick;
      end else if (ack_s) begin
        req_reg      <= 1'b0;
      end else if (ack_m) begin
        req_reg      <= 1'b0;
        m_list_reg   <= m_list_reg & ~(9'h001 << m_cur_reg);
        m_addr_reg   <= m_addr_reg + clsd_pkg::WORD_STEP;
      end
    end
  end

  // ----------------------------------------------------------------
  // issue handshake, completion pulses and register port read
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ready_reg <= 1'b0;
      done_reg  <= 1'b0;
      undef_reg <= 1'b0;
      pcv_reg   <= 1'b0;
      pcval_reg <= 32'h0000_0000;
      rdata_reg <= 32'h0000_0000;
    end else begin
      ready_reg <= state_next == clsd_pkg::ST_IDLE;
      done_reg  <= cw_alu | ack_s | cw_wb;
      undef_reg <= accept & ~(is_alu | is_single | is_multi);
      pcv_reg   <= ack_m & m_load_reg & (m_cur_reg == clsd_pkg::IDX_EXTRA);
      if (ack_m & m_load_reg & (m_cur_reg == clsd_pkg::IDX_EXTRA)) begin
        pcval_reg <= mem_rdata;
      end
      rdata_reg <= reg_rd ? rd_mux : 32'h0000_0000;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign instr_ready   = ready_reg;
  assign instr_done    = done_reg;
  assign instr_undef   = undef_reg;
  assign pc_load_valid = pcv_reg;
  assign pc_load_value = pcval_reg;
  assign mem_req       = req_reg;
  assign mem_we        = we_reg;
  assign mem_addr      = addr_reg;
  assign mem_wdata     = wdata_reg;
  assign mem_size      = size_reg;
  assign reg_rdata     = rdata_reg;
  assign flag_n        = n_reg;
  assign flag_z        = z_reg;
  assign flag_c        = c_reg;
  assign flag_v        = v_reg;

endmodule // clsd_core

`default_nettype wire

// *** common/clsd_pkg.sv ***
// package for the compact load/store and add decode block
// holds opcode patterns, field positions, sizes, register indices and states
package clsd_pkg;

  // ----------------------------------------------------------------
  // widths and register file layout
  // ----------------------------------------------------------------
  localparam int          NUM_REGS    = 10;
  localparam logic [3:0]  IDX_SP      = 4'h8;   // stack pointer slot
  localparam logic [3:0]  IDX_LR      = 4'h9;   // return address slot
  localparam logic [3:0]  IDX_EXTRA   = 4'h8;   // list bit for lr / pc
  localparam logic [3:0]  ADDR_FLAGS  = 4'hA;   // port address of nzcv
  localparam logic [3:0]  ADDR_STATUS = 4'hB;   // port address of busy

  // ----------------------------------------------------------------
  // instruction field positions (lsb of each field)
  // ----------------------------------------------------------------
  localparam int F_RD   = 0;
  localparam int F_RN   = 3;
  localparam int F_RM   = 6;
  localparam int F_IMM5 = 6;
  localparam int F_HRD  = 8;
  localparam int F_IMM8 = 0;
  localparam int F_ROP  = 9;
  localparam int F_RBIT = 8;
  localparam int F_PP   = 10;
  localparam int F_LBIT = 11;
  localparam int F_BBIT = 12;

  // ----------------------------------------------------------------
  // opcode patterns, matched against the top bits of the instruction
  // ----------------------------------------------------------------
  localparam logic [9:0] OP_ADC    = 10'h105;  // bits 15:6
  localparam logic [6:0] OP_ADD3   = 7'h0E;    // bits 15:9
  localparam logic [4:0] OP_ADD8   = 5'h06;    // bits 15:11
  localparam logic [2:0] OP_IMM_WB = 3'h3;     // bits 15:13
  localparam logic [3:0] OP_IMM_H  = 4'h8;     // bits 15:12
  localparam logic [3:0] OP_REG    = 4'h5;     // bits 15:12
  localparam logic [4:0] OP_LIT    = 5'h09;    // bits 15:11
  localparam logic [3:0] OP_SP     = 4'h9;     // bits 15:12
  localparam logic [3:0] OP_PP     = 4'hB;     // bits 15:12, bit 10 set
  localparam logic [3:0] OP_BLK    = 4'hC;     // bits 15:12

  // register-offset operation select, bits 11:9
  localparam logic [2:0] ROP_WORD_STORE        = 3'h0;
  localparam logic [2:0] ROP_HALF_STORE        = 3'h1;
  localparam logic [2:0] ROP_BYTE_STORE        = 3'h2;
  localparam logic [2:0] ROP_SIGNED_BYTE_LOAD  = 3'h3;
  localparam logic [2:0] ROP_WORD_LOAD         = 3'h4;
  localparam logic [2:0] ROP_UNSIGNED_HALF_LD  = 3'h5;
  localparam logic [2:0] ROP_UNSIGNED_BYTE_LD  = 3'h6;
  localparam logic [2:0] ROP_SIGNED_HALF_LOAD  = 3'h7;

  // ----------------------------------------------------------------
  // transfer sizes and address arithmetic
  // ----------------------------------------------------------------
  localparam logic [1:0]  SZ_BYTE    = 2'h0;
  localparam logic [1:0]  SZ_HALF    = 2'h1;
  localparam logic [1:0]  SZ_WORD    = 2'h2;
  localparam int          SCALE_WORD = 2;
  localparam int          SCALE_HALF = 1;
  localparam logic [31:0] WORD_STEP  = 32'h0000_0004;
  localparam logic [31:0] PC_ALIGN   = 32'hFFFF_FFFC;

  // ----------------------------------------------------------------
  // sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_SWAIT,
    ST_MISSUE,
    ST_MWAIT,
    ST_MWB
  } clsd_state_t;

endpackage

// *** verif/clsd_mem_model.sv ***
// memory model on the core data port
// assumes one clock; ack comes lat cycles after the request, one cycle when lat is 0
`timescale 1ns/1ps
`default_nettype none
module clsd_mem_model (
  // clock, reset, latency
  input  wire logic        clk,
  input  wire logic        reset_n,
  input  wire logic [1:0]  lat,
  // data port
  input  wire logic        mem_req,
  input  wire logic        mem_we,
  input  wire logic [31:0] mem_addr,
  input  wire logic [31:0] mem_wdata,
  input  wire logic [1:0]  mem_size,
  output logic             mem_ack,
  output logic [31:0]      mem_rdata
);
  logic [31:0] mem [64];
  logic [1:0]  cnt;
  logic [31:0] msk;
  logic [4:0]  sh;
  // lane mask and shift of the access
  assign msk = (mem_size == 2'h0) ? 32'h0000_00ff : (mem_size == 2'h1) ? 32'h0000_ffff : 32'hffff_ffff;
  assign sh  = {mem_addr[1:0], 3'h0};
  // one ack per request; idle data lines toggle
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      mem_ack <= 1'b0;
      cnt <= 2'h0;
      mem_rdata <= 32'h0000_0000;
    end else if (mem_ack || !mem_req) begin
      mem_ack <= 1'b0;
      cnt <= 2'h0;
      mem_rdata <= ~mem_rdata;
    end else if (cnt + 2'h1 >= lat) begin
      mem_ack <= 1'b1;
      mem_rdata <= mem[mem_addr[7:2]] >> sh;
      if (mem_we) mem[mem_addr[7:2]] <= (mem[mem_addr[7:2]] & ~(msk << sh)) | ((mem_wdata & msk) << sh);
    end else begin
      cnt <= cnt + 2'h1;
    end
  end
endmodule // clsd_mem_model
`default_nettype wire

// *** verif/clsd_core_asserts.sv ***
// port assertions for the core
// assumes it is bound to clsd_core
`timescale 1ns/1ps
`default_nettype none
module clsd_core_asserts (
  // clock and reset
  input wire logic        clk,
  input wire logic        reset_n,
  // issue
  input wire logic        instr_valid,
  input wire logic [15:0] instr,
  input wire logic [31:0] instr_pc,
  input wire logic        instr_ready,
  input wire logic        instr_done,
  // memory and register port
  input wire logic        mem_req,
  input wire logic        mem_we,
  input wire logic [31:0] mem_addr,
  input wire logic [1:0]  mem_size,
  input wire logic        mem_ack,
  input wire logic        reg_rd,
  input wire logic [31:0] reg_rdata
);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  logic tk;
  assign tk = instr_valid && instr_ready; // instruction taken
  a_add8_done: assert property (tk && instr[15:11] == clsd_pkg::OP_ADD8 |=> instr_done && instr_ready)
    else $error("add8 late");
  a_adc_done: assert property (tk && instr[15:6] == clsd_pkg::OP_ADC |=> instr_done)
    else $error("adc late");
  a_add3_done: assert property (tk && instr[15:9] == clsd_pkg::OP_ADD3 |=> instr_done)
    else $error("add3 late");
  a_lit_addr: assert property (tk && instr[15:11] == clsd_pkg::OP_LIT |=> mem_req && !mem_we &&
    mem_addr == ($past(instr_pc) & 32'hffff_fffc) + {22'h0, $past(instr[7:0]), 2'h0}) else $error("lit addr");
  a_imm_size: assert property (tk && instr[15:13] == clsd_pkg::OP_IMM_WB |=>
    mem_size == ($past(instr[12]) ? clsd_pkg::SZ_BYTE : clsd_pkg::SZ_WORD)) else $error("imm size");
  a_sp_dir: assert property (tk && instr[15:12] == clsd_pkg::OP_SP |=> mem_req && mem_we == !$past(instr[11]))
    else $error("sp dir");
  a_req_hold: assert property (mem_req && !mem_ack |=> mem_req && $stable(mem_addr))
    else $error("req drop");
  a_ack_rel: assert property (mem_req && mem_ack |=> !mem_req)
    else $error("req stuck");
  a_rdata_idle: assert property (!reg_rd |=> reg_rdata == 32'h0000_0000)
    else $error("rdata idle");
  c_push: cover property (tk && instr[15:12] == clsd_pkg::OP_PP);
  c_store: cover property (mem_ack && mem_we);
  c_adc: cover property (tk && instr[15:6] == clsd_pkg::OP_ADC);
endmodule // clsd_core_asserts
bind clsd_core clsd_core_asserts u_asrt (.clk(clk), .reset_n(reset_n), .instr_valid(instr_valid), .instr(instr),
  .instr_pc(instr_pc), .instr_ready(instr_ready), .instr_done(instr_done), .mem_req(mem_req), .mem_we(mem_we),
  .mem_addr(mem_addr), .mem_size(mem_size), .mem_ack(mem_ack), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
`default_nettype wire

// *** verif/tb_top.sv ***
// self-checking bench for clsd_core
// assumes the memory model on the data port
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  typedef struct packed {logic [15:0] op; logic [3:0] ra; logic [31:0] v; logic [3:0] f;} clsd_row_t;
  logic clk = 1'b0, reset_n = 1'b0, instr_valid = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, u;
  logic [15:0] instr = 16'h0000;
  logic [31:0] instr_pc = 32'h0000_0086, reg_wdata = 32'h0000_0000, v;
  logic [3:0]  reg_addr = 4'h0;
  logic [1:0]  lat = 2'h1, mem_size;
  logic instr_ready, instr_done, instr_undef, pc_load_valid, mem_req, mem_we, mem_ack, fn, fz, fc, fv;
  logic [31:0] pc_load_value, mem_addr, mem_wdata, mem_rdata, reg_rdata;
  int err_count = 0, checks_done = 0;
  int pcv_cnt = 0;
  logic [31:0] pre [10] = '{32'h7fff_ff01, 32'h0000_0040, 32'h0000_0004, 32'h8081_f2e3, 32'h0000_0000,
    32'h0000_0000, 32'h0000_0000, 32'hffff_fff9, 32'h0000_0080, 32'h1234_5678};
  // op, register, value, flags nzcv
  clsd_row_t rows [22] = '{'{16'h30ff, 4'h0, 32'h8000_0000, 4'h9}, '{16'h1dfc, 4'h4, 32'h0000_0000, 4'h6},
    '{16'h4140, 4'h0, 32'h0000_0001, 4'h3}, '{16'h4164, 4'h4, 32'h0000_0001, 4'h0},
    '{16'h604b, 4'h3, 32'h8081_f2e3, 4'h0}, '{16'h588c, 4'h4, 32'h8081_f2e3, 4'h0},
    '{16'h790d, 4'h5, 32'h0000_00e3, 4'h0}, '{16'h568e, 4'h6, 32'hffff_ffe3, 4'h0},
    '{16'h888f, 4'h7, 32'h0000_f2e3, 4'h0}, '{16'h5e8e, 4'h6, 32'hffff_f2e3, 4'h0},
    '{16'h9302, 4'h3, 32'h8081_f2e3, 4'h0}, '{16'h9d02, 4'h5, 32'h8081_f2e3, 4'h0},
    '{16'h4e01, 4'h6, 32'h8081_f2e3, 4'h0}, '{16'hc128, 4'h1, 32'h0000_0048, 4'h0},
    '{16'hb508, 4'h8, 32'h0000_0078, 4'h0}, '{16'hbd01, 4'h8, 32'h0000_0080, 4'h0},
    '{16'h604b, 4'h3, 32'h8081_f2e3, 4'h0}, '{16'h718a, 4'h2, 32'h0000_0004, 4'h0},
    '{16'h5289, 4'h1, 32'h0000_0048, 4'h0}, '{16'h684d, 4'h5, 32'h8004_0048, 4'h0},
    '{16'h5a88, 4'h0, 32'h0000_0048, 4'h0}, '{16'h5c8e, 4'h6, 32'h0000_0048, 4'h0}};
  always #2.5 clk = ~clk;
  // count pulses of the pc load strobe
  always @(posedge clk) begin
    if (pc_load_valid === 1'b1) begin
      pcv_cnt <= pcv_cnt + 1;
    end
  end
  clsd_core u_dut (.clk(clk), .reset_n(reset_n), .instr_valid(instr_valid), .instr(instr), .instr_pc(instr_pc),
    .instr_ready(instr_ready), .instr_done(instr_done), .instr_undef(instr_undef), .pc_load_valid(pc_load_valid),
    .pc_load_value(pc_load_value), .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
    .mem_size(mem_size), .mem_ack(mem_ack), .mem_rdata(mem_rdata), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .flag_n(fn), .flag_z(fz), .flag_c(fc), .flag_v(fv));
  clsd_mem_model u_mem (.clk(clk), .reset_n(reset_n), .lat(lat), .mem_req(mem_req), .mem_we(mem_we),
    .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_size(mem_size), .mem_ack(mem_ack), .mem_rdata(mem_rdata));
  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    checks_done++;
    if (s !== e) begin
      err_count++;
      $display("MISMATCH %s exp %h seen %h", nm, e, s);
    end
  endtask
  task automatic end_sim;
    $display("errors %0d checks %0d", err_count, checks_done);
    if (err_count == 0 && checks_done > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  // read strobe, data sampled in the following cycle
  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 chk("reg", reg_rdata, e);
  endtask
  // wait idle, present one cycle, wait done or undef
  task automatic issue(input logic [15:0] op);
    int n;
    for (n = 0; n < 60 && instr_ready !== 1'b1; n++) @(negedge clk);
    if (n == 60) begin
      chk("ready", 32'h0000_0000, 32'h0000_0001);
      end_sim();
    end
    @(posedge clk);
    instr <= op;
    instr_valid <= 1'b1;
    @(posedge clk);
    instr_valid <= 1'b0;
    for (n = 0; n < 60 && instr_done !== 1'b1 && instr_undef !== 1'b1; n++) @(negedge clk);
    u = instr_undef;
    if (n == 60) begin
      chk("timeout", 32'h0000_0001, 32'h0000_0000);
      end_sim();
    end
  endtask
  initial begin
    repeat (4) @(posedge clk);
    reset_n <= 1'b1;
    foreach (pre[i]) wr(4'(i), pre[i]);
    foreach (rows[i]) begin
      lat <= 2'(i % 3 + 1);
      issue(rows[i].op);
      chk("undef", {31'h0, u}, 32'h0000_0000);
      chk("flags", {28'h0, fn, fz, fc, fv}, {28'h0, rows[i].f});
      rd(rows[i].ra, rows[i].v);
    end
    chk("pc_load", pc_load_value, 32'h1234_5678);
    chk("pc_load_valid", pcv_cnt, 32'h0000_0001);
    wr(4'h1, 32'h0000_0040);
    issue(16'hc9c0);
    rd(4'h7, 32'h8081_f2e3);
    rd(4'h1, 32'h0000_0048);
    issue(16'hc200);
    rd(4'h2, 32'h0000_0004);
    issue(16'he800);
    chk("undef", {31'h0, u}, 32'h0000_0001);
    rd(4'hc, 32'h0000_0000);
    wr(4'hb, 32'hffff_ffff);
    rd(4'hb, 32'h0000_0000);
    issue(16'h790d);
    @(posedge clk);
    reset_n <= 1'b0;
    @(negedge clk);
    chk("size", {30'h0, mem_size}, {30'h0, clsd_pkg::SZ_WORD});
    chk("pc_load", pc_load_value, 32'h0000_0000);
    @(posedge clk);
    reset_n <= 1'b1;
    rd(4'h3, 32'h0000_0000);
    end_sim();
  end
endmodule // tb_top
`default_nettype wire
